// >>> rcm_command_map.sv
`timescale 1ns/1ps
`default_nettype none
module rcm_command_map
  import rcm_pkg::*;
#(
  parameter logic [3:0] DEVICE_CODE = 4'ha  // Arbitrary value
) (
  // Clock, enable and reset
  input  wire logic        clk,
  input  wire logic        ce,
  input  wire logic        arst_n,
  // Serial pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  // Timekeeping side
  input  wire logic [55:0] time_live,
  input  wire logic        alarm_one_hit,
  input  wire logic        alarm_two_hit,
  input  wire logic        low_voltage_detect,
  output var  logic        time_load_all,
  output var  logic        time_load_clock,
  output var  logic [55:0] time_wr,
  // Configuration
  output var  rcm_cfg_type cfg,
  output var  logic        init_pulse
);

  function automatic logic [7:0] get56(input logic [55:0] v, input logic [2:0] i);
    int sh;
    sh = 8 * (6 - int'(i));
    return 8'(v >> sh);
  endfunction

  function automatic logic [55:0] put56(input logic [55:0] v, input logic [2:0] i,
                                        input logic [7:0] b);
    int          sh;
    logic [55:0] m;
    sh = 8 * (6 - int'(i));
    m  = {48'h0, 8'hff} << sh;
    return (v & ~m) | ({48'h0, b} << sh);
  endfunction

  function automatic logic [7:0] get24(input logic [23:0] v, input logic [2:0] i);
    return get56({32'h0, v}, 3'(i + HMS_BASE));
  endfunction

  function automatic logic [23:0] put24(input logic [23:0] v, input logic [2:0] i,
                                        input logic [7:0] b);
    logic [55:0] w;
    w = put56({32'h0, v}, 3'(i + HMS_BASE), b);
    return w[23:0];
  endfunction

  function automatic logic alarm_mode(input logic al, input logic mn, input logic fr);
    return al & ~mn & ~fr;
  endfunction

  function automatic logic freq_mode(input logic mn, input logic fr);
    return ~mn & fr;
  endfunction

  // Byte length of a command; zero marks an unlisted combination
  function automatic logic [2:0] cmd_len(input logic [2:0] c, input logic [7:0] s2);
    logic [2:0] n;
    n = LEN_NONE;
    case (c)
      CMD_CAL: n = LEN_CAL;
      CMD_HMS: n = LEN_HMS;
      CMD_OUT1: begin
        if (alarm_mode(s2[ST2_O1_AL], s2[ST2_O1_MIN], s2[ST2_O1_FREQ])) begin
          n = LEN_ALARM;
        end else if (freq_mode(s2[ST2_O1_MIN], s2[ST2_O1_FREQ])) begin
          n = LEN_ONE;
        end
      end
      CMD_OUT2: begin
        if (alarm_mode(s2[ST2_O2_AL], s2[ST2_O2_MIN], s2[ST2_O2_FREQ])) begin
          n = LEN_ALARM;
        end else if (freq_mode(s2[ST2_O2_MIN], s2[ST2_O2_FREQ])) begin
          n = LEN_ONE;
        end
      end
      default: n = LEN_ONE;
    endcase
    return n;
  endfunction

  // Reset release
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pin sampling; idle bus lines sit high
  logic [2:0] pins;
  logic       scl_s;
  logic       sda_s;
  logic       lv_s;
  logic       scl_q;
  logic       sda_q;

  rcm_sync #(
    .WIDTH (3),
    .INIT  (SYNC_INIT)
  ) u_sync (
    .clk   (clk),
    .ce    (ce),
    .rst_n (rst_n),
    .d     ({scl_in, sda_in, low_voltage_detect}),
    .q     (pins)
  );
  assign scl_s = pins[2];
  assign sda_s = pins[1];
  assign lv_s  = pins[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise   = ce & scl_s & ~scl_q;
  assign scl_fall   = ce & ~scl_s & scl_q;
  assign start_cond = ce & scl_s & scl_q & sda_q & ~sda_s;
  assign stop_cond  = ce & scl_s & scl_q & ~sda_q & sda_s;

  // Protocol state
  rcm_state_type state;
  logic [3:0]    cnt;
  logic          half;
  logic          mack;
  logic [7:0]    sh;
  logic [2:0]    cmd;
  logic          rw;
  logic [2:0]    idx;
  logic [2:0]    len;
  logic [55:0]   snap;
  logic          al1_flag;
  logic          al2_flag;
  logic          lv_flag;
  logic          poc_flag;

  logic [7:0] sh_in;
  logic [2:0] next_len;
  logic       addr_ok;
  logic       addr_done;
  logic       rd_load;
  logic       rd_stb;
  logic       wr_stb;
  logic       init_stb;
  logic [7:0] rd_byte;
  logic       o1_alarm;
  logic       o2_alarm;

  assign sh_in     = {sh[6:0], sda_s};
  assign next_len  = cmd_len(sh_in[3:1], cfg.status_two);
  assign addr_ok   = (sh_in[7:4] == DEVICE_CODE) && (next_len != LEN_NONE); // [RQ1] [RQ2]
  assign addr_done = (state == ST_ADDR) && scl_rise && (cnt == BIT_LAST);
  assign rd_load   = scl_fall && !start_cond && !stop_cond &&
                     (((state == ST_AACK) && half && rw) || ((state == ST_RACK) && half && mack));
  assign rd_stb    = rd_load && (idx < len);
  assign wr_stb    = (state == ST_WDATA) && scl_rise && !start_cond && !stop_cond &&
                     (cnt == BIT_LAST) && (idx < len); // [RQ22]
  assign init_stb  = wr_stb && (cmd == CMD_STAT1) && sh_in[ST1_INIT]; // [RQ14]
  assign o1_alarm  = alarm_mode(cfg.status_two[ST2_O1_AL], cfg.status_two[ST2_O1_MIN],
                                cfg.status_two[ST2_O1_FREQ]);
  assign o2_alarm  = alarm_mode(cfg.status_two[ST2_O2_AL], cfg.status_two[ST2_O2_MIN],
                                cfg.status_two[ST2_O2_FREQ]);
  assign sda_out   = 1'b0;

  // Byte presented for a read at the current index
  always_comb begin
    rd_byte = IDLE_BYTE; // [RQ22]
    if (idx < len) begin
      case (cmd)
        CMD_STAT1: begin
          rd_byte = {1'b0, cfg.hour_mode, cfg.scratch, al1_flag, al2_flag, lv_flag,
                     poc_flag}; // [RQ3] [RQ14] [RQ15]
        end
        CMD_STAT2: rd_byte = cfg.status_two; // [RQ4]
        CMD_CAL:   rd_byte = get56(snap & CAL_MASK, idx); // [RQ5] [RQ7] [RQ20]
        CMD_HMS:   rd_byte = get56(snap & CAL_MASK, 3'(idx + HMS_BASE)); // [RQ6]
        CMD_OUT1:  rd_byte = get24(cfg.out_one, idx); // [RQ8] [RQ9]
        CMD_OUT2:  rd_byte = get24(cfg.out_two, idx); // [RQ10] [RQ11]
        CMD_CORR:  rd_byte = cfg.correction; // [RQ12]
        default:   rd_byte = cfg.user_byte; // [RQ13]
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= ST_IDLE;
      cnt    <= 4'h0;
      half   <= 1'b0;
      mack   <= 1'b0;
      sh     <= 8'h00;
      cmd    <= CMD_STAT1;
      rw     <= 1'b0;
      idx    <= 3'h0;
      len    <= LEN_NONE;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      state  <= ST_ADDR;
      cnt    <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (ce) begin
      case (state)
        ST_ADDR: begin
          if (scl_rise) begin
            sh  <= sh_in;
            cnt <= 4'(cnt + 4'h1);
            if (cnt == BIT_LAST) begin
              if (addr_ok) begin
                state <= ST_AACK;
                half  <= 1'b0;
                cmd   <= sh_in[3:1];
                rw    <= sh_in[0];
                idx   <= 3'h0;
                len   <= next_len;
              end else begin
                state <= ST_IDLE; // [RQ2]
              end
            end
          end
        end
        ST_AACK, ST_WACK: begin
          if (scl_rise) begin
            half <= 1'b1;
          end else if (scl_fall) begin
            if (!half) begin
              sda_oe <= 1'b1;
            end else if (rw) begin
              state  <= ST_RDATA;
              sda_oe <= ~rd_byte[7];
              sh     <= {rd_byte[6:0], 1'b0};
              cnt    <= 4'h1;
              idx    <= (idx == IDX_LAST) ? idx : 3'(idx + 3'h1);
            end else begin
              state  <= ST_WDATA;
              sda_oe <= 1'b0;
              cnt    <= 4'h0;
            end
          end
        end
        ST_WDATA: begin
          if (scl_rise) begin
            sh  <= sh_in;
            cnt <= 4'(cnt + 4'h1);
            if (cnt == BIT_LAST) begin
              state <= ST_WACK;
              half  <= 1'b0;
              idx   <= (idx == IDX_LAST) ? idx : 3'(idx + 3'h1);
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt == BIT_COUNT) begin
              sda_oe <= 1'b0;
              state  <= ST_RACK;
              half   <= 1'b0;
            end else begin
              sda_oe <= ~sh[7];
              sh     <= {sh[6:0], 1'b0};
              cnt    <= 4'(cnt + 4'h1);
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            half <= 1'b1;
            mack <= ~sda_s;
          end else if (scl_fall && half) begin
            if (mack) begin
              state  <= ST_RDATA;
              sda_oe <= ~rd_byte[7];
              sh     <= {rd_byte[6:0], 1'b0};
              cnt    <= 4'h1;
              idx    <= (idx == IDX_LAST) ? idx : 3'(idx + 3'h1);
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Snapshot keeps a carry during the read from tearing the bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snap <= 56'h0;
    end else if (addr_done && addr_ok && sh_in[0] && !start_cond && !stop_cond) begin
      snap <= time_live; // [RQ21]
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
    end else if (init_stb) begin
      cfg <= CFG_RESET; // [RQ14]
    end else if (wr_stb) begin
      case (cmd)
        CMD_STAT1: begin
          cfg.hour_mode <= sh_in[ST1_HOUR]; // [RQ3]
          cfg.scratch   <= sh_in[ST1_SC_HI:ST1_SC_LO]; // [RQ15]
        end
        CMD_STAT2: cfg.status_two <= sh_in; // [RQ4]
        CMD_OUT1: begin
          cfg.out_one <= put24(cfg.out_one, idx,
                               o1_alarm ? (sh_in & get24(ALARM_MASK, idx)) : sh_in); // [RQ7] [RQ8] [RQ9]
        end
        CMD_OUT2: begin
          cfg.out_two <= put24(cfg.out_two, idx,
                               o2_alarm ? (sh_in & get24(ALARM_MASK, idx)) : sh_in); // [RQ10] [RQ11]
        end
        CMD_CORR:  cfg.correction <= sh_in; // [RQ12]
        CMD_USER:  cfg.user_byte <= sh_in; // [RQ13]
        default:   cfg <= cfg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_pulse <= 1'b0;
    end else if (ce) begin
      init_pulse <= init_stb; // [RQ14]
    end
  end

  // Flags: a hit in the clearing cycle wins
  logic clr_flags;
  assign clr_flags = rd_stb && (cmd == CMD_STAT1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      al1_flag <= 1'b0;
      al2_flag <= 1'b0;
      lv_flag  <= 1'b0;
      poc_flag <= 1'b1; // [RQ17]
    end else if (ce) begin
      al1_flag <= (al1_flag & ~clr_flags & ~init_stb) | (alarm_one_hit & o1_alarm); // [RQ16]
      al2_flag <= (al2_flag & ~clr_flags & ~init_stb) | (alarm_two_hit & o2_alarm); // [RQ16]
      lv_flag  <= (lv_flag & ~init_stb) | lv_s; // [RQ17]
      poc_flag <= poc_flag & ~clr_flags & ~init_stb; // [RQ17]
    end
  end

  // Calendar writes gathered, then handed over whole
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      time_wr         <= 56'h0;
      time_load_all   <= 1'b0;
      time_load_clock <= 1'b0;
    end else if (ce) begin
      time_load_all   <= wr_stb && (cmd == CMD_CAL) && (idx == 3'(LEN_CAL - 3'h1)); // [RQ5]
      time_load_clock <= wr_stb && (cmd == CMD_HMS) && (idx == 3'(LEN_HMS - 3'h1)); // [RQ6]
      if (wr_stb && (cmd == CMD_CAL)) begin
        time_wr <= put56(time_wr, idx, sh_in & get56(CAL_MASK, idx)); // [RQ7] [RQ20]
      end else if (wr_stb && (cmd == CMD_HMS)) begin
        time_wr <= put56(time_wr, 3'(idx + HMS_BASE),
                         sh_in & get56(CAL_MASK, 3'(idx + HMS_BASE))); // [RQ6] [RQ7]
      end
    end
  end

endmodule // rcm_command_map
`default_nettype wire

// >>> rcm_pkg.sv
// Functional notes
// RQ1: Fixed four-bit device code, then one of eight three-bit commands selecting a group.
// RQ2: Wrong device code or unlisted command combination: no acknowledge, no action.
// RQ3: Command 000 is status one: init, hour mode, scratch, flags.
// RQ4: Command 001 is status two: output enables, crystal output, test bit.
// RQ5: Command 010 moves seven calendar bytes year first, value bit zero in B7.
// RQ6: Command 011 moves hour, minute, second only, same layout.
// RQ7: Unassigned calendar and alarm bits ignore writes and read zero; alarm reads return stored bytes, masked only on writes made in alarm mode.
// RQ8: Output one alarm mode: command 100 moves weekday, hour, minute alarm bytes.
// RQ9: Output one frequency mode: command 100 moves one frequency plus scratch byte.
// RQ10: Output two alarm mode: command 101 moves weekday, hour, minute alarm bytes.
// RQ11: Output two frequency mode: command 101 moves one frequency plus scratch byte.
// RQ12: Command 110 reads or writes the correction byte, bit zero in B7.
// RQ13: Command 111 reads or writes the free user byte, bit zero in B7.
// RQ14: Initialise bit is write-only; writing one initialises the circuitry.
// RQ15: Scratch bits store and return whatever the host wrote.
// RQ16: Alarm flags set on match in alarm mode, clear when read.
// RQ17: Power-on flag set at power-up, clears after read; low-voltage flag read-only.
// RQ18: Host keeps the factory test bit written as zero.
// RQ19: Host sends start, code, command, direction, bytes from B7, acks, stop.
// RQ20: Calendar fields are BCD across the seven calendar bytes.
// RQ21: A read command latches a coherent time snapshot first.
// RQ22: Bytes beyond a command's length are ignored; extra reads return idle ones.
package rcm_pkg;

  localparam logic [2:0] CMD_STAT1 = 3'h0;
  localparam logic [2:0] CMD_STAT2 = 3'h1;
  localparam logic [2:0] CMD_CAL   = 3'h2;
  localparam logic [2:0] CMD_HMS   = 3'h3;
  localparam logic [2:0] CMD_OUT1  = 3'h4;
  localparam logic [2:0] CMD_OUT2  = 3'h5;
  localparam logic [2:0] CMD_CORR  = 3'h6;
  localparam logic [2:0] CMD_USER  = 3'h7;

  localparam logic [2:0] LEN_NONE  = 3'h0;
  localparam logic [2:0] LEN_ONE   = 3'h1;
  localparam logic [2:0] LEN_HMS   = 3'h3;
  localparam logic [2:0] LEN_ALARM = 3'h3;
  localparam logic [2:0] LEN_CAL   = 3'h7;
  localparam logic [2:0] HMS_BASE  = 3'h4;
  localparam logic [2:0] IDX_LAST  = 3'h7;

  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_COUNT = 4'h8;

  // Status one bit positions
  localparam int ST1_INIT  = 7;
  localparam int ST1_HOUR  = 6;
  localparam int ST1_SC_HI = 5;
  localparam int ST1_SC_LO = 4;
  localparam int ST1_AL1   = 3;
  localparam int ST1_AL2   = 2;
  localparam int ST1_LV    = 1;
  localparam int ST1_POC   = 0;

  // Status two bit positions
  localparam int ST2_O1_FREQ = 7;
  localparam int ST2_O1_MIN  = 6;
  localparam int ST2_O1_AL   = 5;
  localparam int ST2_XTAL    = 4;
  localparam int ST2_O2_FREQ = 3;
  localparam int ST2_O2_MIN  = 2;
  localparam int ST2_O2_AL   = 1;
  localparam int ST2_TEST    = 0;

  // Live bit masks, wire order, first byte in the top bits
  localparam logic [55:0] CAL_MASK   = 56'hff_f8_fc_e0_fe_fe_fe;
  localparam logic [23:0] ALARM_MASK = 24'he1_ff_ff;
  localparam logic [7:0]  IDLE_BYTE  = 8'hff;

  localparam logic [2:0] SYNC_INIT = 3'h6;

  typedef struct packed {
    logic        hour_mode;
    logic [1:0]  scratch;
    logic [7:0]  status_two;
    logic [23:0] out_one;
    logic [23:0] out_two;
    logic [7:0]  correction;
    logic [7:0]  user_byte;
  } rcm_cfg_type;

  localparam rcm_cfg_type CFG_RESET = '0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_AACK  = 3'h3,
    ST_WDATA = 3'h2,
    ST_WACK  = 3'h6,
    ST_RDATA = 3'h7,
    ST_RACK  = 3'h5
  } rcm_state_type;

endpackage

// >>> rcm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rcm_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // Clock, enable and reset
  input  wire logic             clk,
  input  wire logic             ce,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // One process for all bits, so each flop has a single writer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      q    <= INIT;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // rcm_sync
`default_nettype wire

// >>> rcm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rcm_chk
  import rcm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Watched ports
  input  wire logic        scl_in,
  input  wire logic        sda_out,
  input  wire logic        sda_oe,
  input  wire logic        time_load_all,
  input  wire logic        time_load_clock,
  input  wire logic [55:0] time_wr,
  input  wire rcm_cfg_type cfg,
  input  wire logic        init_pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_open_drain: assert property (sda_out == 1'b0)
    else $error("sda_out driven high");
  // Data may only move while the bus clock is low
  a_drive_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda_oe moved with scl high");
  a_hold_high: assert property ($rose(scl_in) |=> $stable(sda_oe) [*4])
    else $error("sda_oe not held in clock high");
  a_cal_pulse: assert property (time_load_all |=> !time_load_all)
    else $error("time_load_all longer than one cycle");
  a_hms_pulse: assert property (time_load_clock |=> !time_load_clock)
    else $error("time_load_clock longer than one cycle");
  a_init_once: assert property (init_pulse |=> !init_pulse)
    else $error("init_pulse longer than one cycle");
  a_cal_mask: assert property (time_load_all |-> (time_wr & ~CAL_MASK) == '0)
    else $error("unassigned calendar bit written");
  a_hms_mask: assert property (time_load_clock |-> (time_wr[23:0] & ~CAL_MASK[23:0]) == '0)
    else $error("unassigned clock bit written");
  a_init_clear: assert property (init_pulse |-> ##[0:2] cfg == CFG_RESET)
    else $error("cfg not cleared by init");
  a_commit_high: assert property (($changed(cfg) || time_load_all) |-> scl_in)
    else $error("commit outside clock high");

  c_cal: cover property (time_load_all);
  c_hms: cover property (time_load_clock);
  c_init: cover property (init_pulse);
  c_ack: cover property ($rose(sda_oe));
endmodule // rcm_chk
`default_nettype wire

// >>> rcm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcm_host_model (
  // Bus pins, sda_drv high pulls data low
  output var  logic scl,
  output var  logic sda_drv,
  input  wire logic sda_wire
);
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b0;
  end
  // Clock stands high between frames
  task automatic start();
    sda_drv = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_drv = 1'b1;
    #Q;
    scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_drv = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_drv = 1'b0;
    #(2*Q);
  endtask
  // Data set mid low phase, sampled late in high phase
  task automatic bit_io(input logic v, output logic s);
    sda_drv = ~v;
    #Q;
    scl = 1'b1;
    #(2*Q);
    s = sda_wire;
    scl = 1'b0;
    #Q;
  endtask
  // Eight bits from B7, then the acknowledge slot
  task automatic xbyte(input logic [7:0] wb, input logic ai, output logic [7:0] rb,
                       output logic ao);
    for (int i = 7; i >= 0; i--) begin
      bit_io(wb[i], rb[i]);
    end
    bit_io(ai, ao);
  endtask
endmodule // rcm_host_model
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rcm_pkg::*;
  localparam logic [3:0] DEV = 4'h5; // Arbitrary value
  logic        clk, arst_n, ce, scl, sda_drv, sda_oe, sda_out;
  logic        al1, al2, lvd, ld_all, ld_hms, init_p, nak, seen;
  logic [55:0] live, twr;
  logic [7:0]  wq [8];
  logic [7:0]  rq [8];
  rcm_cfg_type cfg;
  int          error_cnt, check_count, cyc, n_all, n_hms;
  int          seed = 89859;
  wire logic   sda = ~sda_drv & (~sda_oe | sda_out);

  rcm_command_map #(.DEVICE_CODE(DEV)) rcm_command_map_inst (
    .clk(clk), .ce(ce), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .time_live(live), .alarm_one_hit(al1), .alarm_two_hit(al2),
    .low_voltage_detect(lvd), .time_load_all(ld_all), .time_load_clock(ld_hms),
    .time_wr(twr), .cfg(cfg), .init_pulse(init_p));
  rcm_host_model rcm_host_model_inst (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (init_p) seen <= 1'b1;
    if (ld_all) n_all++;
    if (ld_hms) n_hms++;
    if (cyc == 60000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [55:0] e, input logic [55:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic logic [55:0] pk(input logic [7:0] a [8], input int n);
    logic [55:0] v = '0;
    for (int i = 0; i < n; i++) v = {v[47:0], a[i]};
    return v;
  endfunction
  task automatic fill();
    for (int i = 0; i < 8; i++) wq[i] = 8'($random(seed));
  endtask
  // Master acks every read byte but the last
  task automatic xfer(input logic [3:0] code, input logic [2:0] cmd, input logic rd, input int n);
    logic       a;
    logic [7:0] d;
    rcm_host_model_inst.start();
    rcm_host_model_inst.xbyte({code, cmd, rd}, 1'b1, d, nak);
    for (int i = 0; i < n && !nak; i++) begin
      rcm_host_model_inst.xbyte(rd ? 8'hff : wq[i], rd ? (i == n - 1) : 1'b1, rq[i], a);
    end
    rcm_host_model_inst.stop();
  endtask
  task automatic put(input logic [2:0] cmd, input int n);
    xfer(DEV, cmd, 1'b0, n);
  endtask
  task automatic get(input logic [2:0] cmd, input int n);
    xfer(DEV, cmd, 1'b1, n);
  endtask
  task automatic hit(input logic two);
    @(posedge clk);
    if (two) al2 <= 1'b1;
    else al1 <= 1'b1;
    @(posedge clk);
    al1 <= 1'b0;
    al2 <= 1'b0;
  endtask

  initial begin
    logic [55:0] old;
    logic [7:0]  keep;
    logic [2:0]  cmd;
    arst_n = 1'b0;
    ce = 1'b1;
    al1 = 1'b0;
    al2 = 1'b0;
    lvd = 1'b0;
    live = '0;
    seen = 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    get(CMD_STAT1, 1);
    chk("addr ack", 1'b0, nak);
    chk("poc set", 8'h01, rq[0]);
    get(CMD_STAT1, 1);
    chk("poc clear", 8'h00, rq[0]);
    for (int k = 0; k < 4; k++) begin
      fill();
      wq[0][7] = 1'b0;
      put(CMD_STAT1, 1);
      get(CMD_STAT1, 1);
      chk("stat1", {1'b0, wq[0][6:4], 4'h0}, rq[0]);
      fill();
      wq[0][0] = 1'b0;
      put(CMD_STAT2, 1);
      get(CMD_STAT2, 1);
      chk("stat2", wq[0], rq[0]);
      chk("cfg stat2", wq[0], cfg.status_two);
      for (int c = 6; c < 8; c++) begin
        fill();
        put(3'(c), 2);
        get(3'(c), 2);
        chk("one byte", {wq[0], IDLE_BYTE}, {rq[0], rq[1]});
      end
      fill();
      put(CMD_CAL, 7);
      chk("cal wr", pk(wq, 7) & CAL_MASK, twr);
      chk("cal load", 56'(k + 1), 56'(n_all));
      fill();
      put(CMD_HMS, 3);
      chk("hms wr", pk(wq, 3) & CAL_MASK & 56'hff_ffff, twr & 56'hff_ffff);
      chk("hms load", 56'(k + 1), 56'(n_hms));
      old = 56'({$random(seed), $random(seed)});
      @(posedge clk);
      live <= old;
      // Live time moves during the data phase
      fork
        get(CMD_CAL, 7);
        begin
          #1500;
          @(posedge clk);
          live <= ~old;
        end
      join
      chk("cal rd", old & CAL_MASK, pk(rq, 7));
      get(CMD_HMS, 3);
      chk("hms rd", ~old & CAL_MASK & 56'hff_ffff, pk(rq, 3));
    end
    for (int o = 0; o < 2; o++) begin
      cmd = o ? CMD_OUT2 : CMD_OUT1;
      wq[0] = 8'h00;
      put(CMD_STAT2, 1);
      put(cmd, 1);
      chk("no mode", 1'b1, nak);
      wq[0] = o ? 8'h02 : 8'h20;
      put(CMD_STAT2, 1);
      fill();
      put(cmd, 3);
      get(cmd, 3);
      chk("alarm", pk(wq, 3) & ALARM_MASK, pk(rq, 3));
      hit(o[0]);
      get(CMD_STAT1, 1);
      chk("flag", o ? 8'h04 : 8'h08, rq[0] & 8'h0c);
      get(CMD_STAT1, 1);
      chk("flag clr", 8'h00, rq[0] & 8'h0c);
      wq[0] = o ? 8'h08 : 8'h80;
      put(CMD_STAT2, 1);
      fill();
      put(cmd, 1);
      get(cmd, 1);
      chk("freq", wq[0], rq[0]);
    end
    get(CMD_USER, 1);
    keep = rq[0];
    wq[0] = ~keep;
    xfer(~DEV, CMD_USER, 1'b0, 1);
    chk("bad code", 1'b1, nak);
    get(CMD_USER, 1);
    chk("untouched", keep, rq[0]);
    // A frozen block must miss a pin pulse
    @(posedge clk);
    ce <= 1'b0;
    lvd <= 1'b1;
    repeat (5) @(posedge clk);
    lvd <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    get(CMD_STAT1, 1);
    chk("ce freeze", 8'h00, rq[0] & 8'h02);
    @(posedge clk);
    lvd <= 1'b1;
    repeat (5) @(posedge clk);
    lvd <= 1'b0;
    repeat (2) get(CMD_STAT1, 1);
    chk("low volt", 8'h02, rq[0] & 8'h02);
    wq[0] = 8'h80;
    put(CMD_STAT1, 1);
    chk("init seen", 1'b1, seen);
    chk("init cfg", 1'b1, cfg === CFG_RESET);
    get(CMD_STAT1, 1);
    chk("after init", 8'h00, rq[0]);
    close_out();
  end
endmodule // tb_top

bind rcm_command_map rcm_chk rcm_chk_inst (
  .clk(clk), .arst_n(arst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .time_load_all(time_load_all), .time_load_clock(time_load_clock), .time_wr(time_wr),
  .cfg(cfg), .init_pulse(init_pulse));
`default_nettype wire
